// ### tape_seq_pkg.sv
// constants for the tape controller status and sense sequencer
package tape_seq_pkg;
  localparam int CLK_NS = 40;
  // service out delay before it acts (service out 1)
  localparam int SO1_NS = 1800;
  localparam int SO1_CYC = (SO1_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] SO1_LAST = 6'(SO1_CYC - 1);
  // read clock phases, one clock each except load, which holds while the buffer is full
  localparam logic [3:0] PH_STEP = 4'h7;
  localparam logic [3:0] PH_LOAD = 4'h8;
  localparam logic [3:0] PH_TAG = 4'h9;
  localparam logic [3:0] PH_END = 4'hA;
  localparam logic [3:0] PH_END_ENC = 4'hC;
  // sense byte counter
  localparam logic [2:0] SN_LAST_DATA = 3'h4;
  localparam logic [2:0] SN_DONE = 3'h7;
  // command codes
  localparam logic [3:0] CMD_SENSE_NIB = 4'h4;
  localparam logic [7:0] CMD_TIO = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h02;
  localparam logic [7:0] CMD_READ_BK = 8'h0C;
  localparam logic [7:0] CMD_REWIND = 8'h07;
  localparam logic [7:0] CMD_REW_UNL = 8'h0F;
  localparam logic [7:0] CMD_ERASE = 8'h17;
  localparam logic [7:0] CMD_WTM = 8'h1F;
  localparam logic [1:0] CTL_LOW = 2'b11;
  localparam int MS_DC_BIT = 5;
  // status byte bit positions
  localparam int ST_MOD = 1;
  localparam int ST_BUSY = 3;
  localparam int ST_CE = 4;
  localparam int ST_DE = 5;
  localparam int ST_UNIT_CHECK = 6;
  // sense byte 0 bit positions owned here
  localparam int SB_CMD_REJ = 7;
  localparam int SB_BUS_CHK = 5;
  // go line positions
  localparam int GO_READ = 0;
  localparam int GO_WRITE = 1;
  localparam int GO_CTL = 2;
  localparam int GO_SENSE = 3;
  localparam int BUF_W = 9;
  localparam int BUF_D = 2;
endpackage

// ### byte_buf2.sv
// two-entry byte buffer with valid/ready on both sides
`timescale 1ns/100ps
module byte_buf2 (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [tape_seq_pkg::BUF_W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [tape_seq_pkg::BUF_W-1:0] out_data_o
);
  logic [tape_seq_pkg::BUF_W-1:0] mem_r [tape_seq_pkg::BUF_D];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] cnt_r;
  wire push = ce_i & in_valid_i & in_ready_o;
  wire pop = ce_i & out_valid_o & out_ready_i;

  // honest flags from the fill count
  assign in_ready_o = cnt_r != 2'h2;
  assign out_valid_o = cnt_r != 2'h0;
  assign out_data_o = mem_r[rd_ptr_r];

  // storage has no reset, only the pointers matter
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wr_ptr_r <= ~wr_ptr_r;
      if (pop) rd_ptr_r <= ~rd_ptr_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ### tape_status_sense.sv
// status screening, register clear and sense transfer sequencer
// How it works
// - service out drops status in; delayed service out arms gate, set unless drive counting
// - command gate passes decoded command lines, else they stay low
// - read, write, sense keep operational in unless command cleared
// - blocking sets status latches and clears command before status goes out
// - accepted motion command plus delayed service out drops burst and op in
// - motion clear waits for op end, rewind clear for drive rewinding
// - accepted unstacked status clears status latches except unit check
// - command out on status sets stack for read, write, sense only
// - stack clears command, keeps status, raises request in, re-offers status
// - command out on status drops force burst, and op in only when it stacks
// - rejected motion command starts once force burst, select out and op in drop
// - clear on selection-done, stack, disconnect, reject, drive not ready or rewinding except for sense, or pending status
// - non-control runs on clean status; control gets channel end, mode set also device end; TIO gets device end only
// - reject or even command parity set unit check and sense bits
// - drive not ready or rewinding sets unit check, except for sense
// - reject and drive status also clear; bad parity needs none
// - busy from rewinding drive or pending status, both clear the command
// - low nibble 0100 decodes as sense
// - sense read clock: step at 7, load 8, service in 9, end 10 or 12
// - service out per byte clears data; counts 1-4 data, 5-6 zero
// - count 7 with service in low gives end sense
// - command out on sense byte sets stop, early end once service in low
// - new command sense reset clears sense bits and unit check
`timescale 1ns/100ps
module tape_status_sense (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic cmd_strobe_i,
  input wire logic [7:0] bus_out_i,
  input wire logic bus_out_par_i,
  input wire logic service_out_i,
  input wire logic command_out_i,
  input wire logic select_out_i,
  input wire logic disconnect_i,
  input wire logic drive_ready_i,
  input wire logic drive_rewinding_i,
  input wire logic drive_counting_i,
  input wire logic drive_protect_i,
  input wire logic dc_feature_i,
  input wire logic status_pending_i,
  input wire logic op_end_i,
  input wire logic phase_encoded_variant_i,
  input wire logic [31:0] sense_data_i,
  output logic [7:0] bus_in_o,
  output logic bus_in_par_o,
  output logic status_in_o,
  output logic service_in_o,
  output logic operational_in_o,
  output logic burst_mode_o,
  output logic request_in_o,
  output logic cmd_gate_o,
  output logic [3:0] go_lines_o,
  output logic cmd_clear_o,
  output logic unit_check_o,
  output logic end_sense_o,
  output logic early_end_o
);
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_CHECK = 7'b0000010,
    S_STAT = 7'b0000100,
    S_SO1 = 7'b0001000,
    S_SENSE = 7'b0010000,
    S_STACK = 7'b0100000,
    S_WAIT = 7'b1000000
  } seq_state_t;

  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [7:0] cmd_r;
  logic cmd_valid_r;
  logic ce_st_r, de_st_r, busy_st_r, unit_chk_r;
  logic cmd_rej_r, bus_chk_r;
  logic stack_r, stop_r, sent_r, gate_arm_r, clr_pend_r;
  logic force_burst_r, op_in_r, burst_r, req_r, gate_r;
  logic [5:0] dly_r;
  logic [3:0] ph_r;
  logic rc_run_r;
  logic [2:0] sn_cnt_r;
  logic tag_busy_r, sts_tag_r, svc_tag_r;
  logic [7:0] bus_in_r;
  logic bus_in_par_r;
  logic [3:0] go_r;
  logic clr_r, end_r, early_r;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [8:0] buf_in_data;
  logic buf_out_valid;
  logic [8:0] buf_out_data;

  // command decode from the command register
  wire c_sense = cmd_r[3:0] == tape_seq_pkg::CMD_SENSE_NIB;
  wire c_ctl = cmd_r[1:0] == tape_seq_pkg::CTL_LOW;
  wire c_tio = cmd_r == tape_seq_pkg::CMD_TIO;
  wire c_wr = cmd_r == tape_seq_pkg::CMD_WRITE;
  wire c_rd = cmd_r == tape_seq_pkg::CMD_READ || cmd_r == tape_seq_pkg::CMD_READ_BK;
  wire c_wtm = cmd_r == tape_seq_pkg::CMD_WTM;
  wire c_erg = cmd_r == tape_seq_pkg::CMD_ERASE;
  wire c_rew = cmd_r == tape_seq_pkg::CMD_REWIND || cmd_r == tape_seq_pkg::CMD_REW_UNL;
  wire c_ms = c_ctl & (cmd_r[7:6] != 2'b00);
  wire c_dcms = c_ms & cmd_r[tape_seq_pkg::MS_DC_BIT];
  wire c_motion = c_ctl & ~c_ms;
  wire c_burst = c_rd | c_wr | c_sense;

  // initial status screening
  wire odd_cmd = ^{bus_out_par_i, bus_out_i};
  wire rej = cmd_valid_r & (((c_wr | c_wtm | c_erg) & drive_protect_i)
             | (c_dcms & ~dc_feature_i));
  wire prohib = cmd_valid_r & ~c_sense & (~drive_ready_i | drive_rewinding_i);
  wire rew_busy = prohib & drive_rewinding_i;
  wire done_sel = cmd_valid_r & (c_tio | c_ms);
  wire sel_clr = rej | prohib | status_pending_i | disconnect_i | done_sel;
  wire [7:0] st_byte = {1'b0, unit_chk_r, de_st_r, ce_st_r, busy_st_r, 1'b0,
                        busy_st_r & status_pending_i, 1'b0};

  // channel answers to the tag now on bus in
  wire ans_so = tag_busy_r & service_out_i;
  wire ans_co = tag_busy_r & command_out_i;
  wire rc_last = phase_encoded_variant_i ? (ph_r == tape_seq_pkg::PH_END_ENC)
                              : (ph_r == tape_seq_pkg::PH_END);
  wire so1_done = dly_r == tape_seq_pkg::SO1_LAST;
  wire sn_data = sn_cnt_r <= tape_seq_pkg::SN_LAST_DATA;
  wire [7:0] sn_sel = sense_data_i[8 * (32'(sn_cnt_r) - 1) +: 8];
  wire [7:0] sn_b0 = sn_sel | (8'(cmd_rej_r) << tape_seq_pkg::SB_CMD_REJ)
                     | (8'(bus_chk_r) << tape_seq_pkg::SB_BUS_CHK);
  wire [7:0] sn_byte = !sn_data ? 8'h00 : (sn_cnt_r == 3'h1) ? sn_b0 : sn_sel;
  wire sn_push = rc_run_r & (ph_r == tape_seq_pkg::PH_LOAD) & (sn_cnt_r != tape_seq_pkg::SN_DONE);
  wire st_push = (state_r == S_STAT) & ~sent_r;
  wire ph_stall = sn_push & ~buf_in_ready;
  wire motion_clr = clr_pend_r & (c_rew ? drive_rewinding_i : op_end_i);

  // bytes to the channel queue through the buffer
  assign buf_in_valid = st_push | sn_push;
  assign buf_in_data = st_push ? {1'b1, st_byte} : {1'b0, sn_byte};

  byte_buf2 u_buf (
    .clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(buf_in_data),
    .out_valid_o(buf_out_valid),
    .out_ready_i(~tag_busy_r),
    .out_data_o(buf_out_data)
  );

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (cmd_strobe_i) state_nxt = S_CHECK;
      end
      S_CHECK: state_nxt = S_STAT;
      S_STAT: begin
        if (ans_so & sts_tag_r) state_nxt = S_SO1;
        else if (ans_co & sts_tag_r) state_nxt = (cmd_valid_r & c_burst) ? S_STACK : S_WAIT;
      end
      S_SO1: begin
        if (so1_done) state_nxt = (cmd_valid_r & c_sense) ? S_SENSE : S_IDLE;
      end
      S_SENSE: begin
        if (~rc_run_r & ~service_in_o & sn_cnt_r == tape_seq_pkg::SN_DONE) state_nxt = S_IDLE;
        else if (stop_r & ~service_in_o) state_nxt = S_IDLE;
        else if (ans_so) state_nxt = S_SO1;
      end
      S_STACK: begin
        if (select_out_i & ~op_in_r) state_nxt = S_STAT;
      end
      S_WAIT: begin
        if (~op_in_r) state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) state_r <= S_IDLE;
    else if (ce_i) state_r <= state_nxt;
  end

  // command register, sense latches, register clear
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_r <= 8'h00;
      cmd_valid_r <= 1'b0;
      cmd_rej_r <= 1'b0;
      bus_chk_r <= 1'b0;
      clr_r <= 1'b0;
      clr_pend_r <= 1'b0;
    end else if (ce_i) begin
      clr_r <= 1'b0;
      if (state_r == S_IDLE && cmd_strobe_i) begin
        cmd_r <= odd_cmd ? bus_out_i : 8'h00;
        cmd_valid_r <= odd_cmd;
        cmd_rej_r <= 1'b0;
        bus_chk_r <= ~odd_cmd;
      end else if (state_r == S_CHECK) begin
        cmd_rej_r <= rej;
        if (sel_clr) begin
          cmd_valid_r <= 1'b0;
          clr_r <= 1'b1;
        end
      end else if ((state_r == S_STAT) & ans_co & sts_tag_r & cmd_valid_r & c_burst) begin
        cmd_valid_r <= 1'b0;
        clr_r <= 1'b1;
      end else if ((state_r == S_SO1) & so1_done & cmd_valid_r & c_motion) begin
        clr_pend_r <= 1'b1;
      end else if (motion_clr | (gate_r & c_burst & ~c_sense & op_end_i)) begin
        clr_pend_r <= 1'b0;
        cmd_valid_r <= 1'b0;
        clr_r <= 1'b1;
      end else if (state_r == S_SENSE && state_nxt == S_IDLE) begin
        cmd_valid_r <= 1'b0;
      end
    end
  end

  // status latches; unit check only drops on the next sense reset
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ce_st_r <= 1'b0;
      de_st_r <= 1'b0;
      busy_st_r <= 1'b0;
      unit_chk_r <= 1'b0;
    end else if (ce_i) begin
      if (state_r == S_IDLE && cmd_strobe_i) begin
        unit_chk_r <= 1'b0;
      end else if (state_r == S_CHECK) begin
        unit_chk_r <= ~cmd_valid_r | rej | prohib;
        busy_st_r <= rew_busy | status_pending_i;
        ce_st_r <= cmd_valid_r & c_ctl & ~status_pending_i;
        de_st_r <= done_sel & ~status_pending_i;
      end else if ((state_r == S_SO1) & so1_done & ~stack_r) begin
        ce_st_r <= 1'b0;
        de_st_r <= 1'b0;
        busy_st_r <= 1'b0;
      end
    end
  end

  // interface latches: op in, burst, stack, request in
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_in_r <= 1'b0;
      force_burst_r <= 1'b0;
      burst_r <= 1'b0;
      stack_r <= 1'b0;
      req_r <= 1'b0;
    end else if (ce_i) begin
      if (state_r == S_IDLE && cmd_strobe_i) begin
        op_in_r <= 1'b1;
        force_burst_r <= 1'b1;
        burst_r <= 1'b1;
        stack_r <= 1'b0;
      end else if ((state_r == S_STAT) & ans_co & sts_tag_r) begin
        force_burst_r <= 1'b0;
        stack_r <= cmd_valid_r & c_burst;
        if (cmd_valid_r & c_burst) op_in_r <= 1'b0;
      end else if ((state_r == S_SO1) & so1_done & (~cmd_valid_r | c_motion)) begin
        op_in_r <= 1'b0;
        burst_r <= 1'b0;
      end else if (state_r == S_WAIT & ~force_burst_r & ~select_out_i) begin
        op_in_r <= 1'b0;
      end else if (state_r == S_STACK) begin
        req_r <= ~select_out_i;
        if (select_out_i) op_in_r <= 1'b1;
      end else if (state_r == S_SENSE && state_nxt == S_IDLE) begin
        op_in_r <= 1'b0;
        burst_r <= 1'b0;
      end else if (gate_r & c_burst & ~c_sense & op_end_i) begin
        op_in_r <= 1'b0;
        burst_r <= 1'b0;
      end
    end
  end

  // command gate: armed at end of service out 1 or once select out drops in wait, held while drive counts
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_arm_r <= 1'b0;
      gate_r <= 1'b0;
      go_r <= 4'h0;
    end else if (ce_i) begin
      if (state_r == S_IDLE && cmd_strobe_i) begin
        gate_r <= 1'b0;
        gate_arm_r <= 1'b0;
      end else if ((state_r == S_SO1) & so1_done & cmd_valid_r) begin
        gate_arm_r <= 1'b1;
      end else if (state_r == S_WAIT & ~force_burst_r & ~select_out_i & cmd_valid_r) begin
        gate_arm_r <= 1'b1;
      end else if (gate_arm_r & ~drive_counting_i) begin
        gate_arm_r <= 1'b0;
        gate_r <= cmd_valid_r;
      end else if (~cmd_valid_r) begin
        gate_r <= 1'b0;
      end
      // decoded lines pass only through an open gate
      go_r[tape_seq_pkg::GO_READ] <= gate_r & cmd_valid_r & c_rd;
      go_r[tape_seq_pkg::GO_WRITE] <= gate_r & cmd_valid_r & c_wr;
      go_r[tape_seq_pkg::GO_CTL] <= gate_r & cmd_valid_r & c_motion;
      go_r[tape_seq_pkg::GO_SENSE] <= gate_r & cmd_valid_r & c_sense;
    end
  end

  // service out 1 delay and status offer bookkeeping
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dly_r <= 6'h00;
      sent_r <= 1'b0;
    end else if (ce_i) begin
      dly_r <= (state_r == S_SO1) ? dly_r + 6'h01 : 6'h00;
      if (st_push & buf_in_ready) sent_r <= 1'b1;
      else if (state_r != S_STAT) sent_r <= 1'b0;
    end
  end

  // read clock cycle for sense bytes; stalls at load while buffer full
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rc_run_r <= 1'b0;
      ph_r <= 4'h0;
      sn_cnt_r <= 3'h0;
      stop_r <= 1'b0;
    end else if (ce_i) begin
      if (state_r == S_IDLE) begin
        sn_cnt_r <= 3'h0;
        stop_r <= 1'b0;
      end
      if ((state_r == S_SO1) & so1_done & cmd_valid_r & c_sense) begin
        rc_run_r <= 1'b1;
        ph_r <= 4'h1;
      end else if (rc_run_r & ~ph_stall) begin
        ph_r <= ph_r + 4'h1;
        if (ph_r == tape_seq_pkg::PH_STEP) sn_cnt_r <= sn_cnt_r + 3'h1;
        if (rc_last) rc_run_r <= 1'b0;
      end
      if ((state_r == S_SENSE) & ans_co & svc_tag_r) stop_r <= 1'b1;
    end
  end

  // bus in register and tags; byte waits for its phase before service in
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tag_busy_r <= 1'b0;
      sts_tag_r <= 1'b0;
      svc_tag_r <= 1'b0;
      bus_in_r <= 8'h00;
      bus_in_par_r <= 1'b0;
    end else if (ce_i) begin
      if (ans_so | ans_co) begin
        tag_busy_r <= 1'b0;
        sts_tag_r <= 1'b0;
        svc_tag_r <= 1'b0;
        bus_in_r <= 8'h00;
        bus_in_par_r <= 1'b0;
      end else if (~tag_busy_r & buf_out_valid) begin
        tag_busy_r <= 1'b1;
        bus_in_r <= buf_out_data[7:0];
        bus_in_par_r <= ~^buf_out_data[7:0];
        sts_tag_r <= buf_out_data[8];
      end else if (tag_busy_r & ~sts_tag_r & (~rc_run_r | ph_r >= tape_seq_pkg::PH_TAG)) begin
        svc_tag_r <= 1'b1;
      end
    end
  end

  // end of sense pulses
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      end_r <= 1'b0;
      early_r <= 1'b0;
    end else if (ce_i) begin
      end_r <= (state_r == S_SENSE) & ~rc_run_r & ~stop_r & ~svc_tag_r
               & (sn_cnt_r == tape_seq_pkg::SN_DONE);
      early_r <= (state_r == S_SENSE) & stop_r & ~svc_tag_r;
    end
  end

  assign bus_in_o = bus_in_r;
  assign bus_in_par_o = bus_in_par_r;
  assign status_in_o = sts_tag_r;
  assign service_in_o = svc_tag_r;
  assign operational_in_o = op_in_r;
  assign burst_mode_o = burst_r;
  assign request_in_o = req_r;
  assign cmd_gate_o = gate_r;
  assign go_lines_o = go_r;
  assign cmd_clear_o = clr_r;
  assign unit_check_o = unit_chk_r;
  assign end_sense_o = end_r;
  assign early_end_o = early_r;
endmodule

// ### tape_status_sense_assertions.sv
// concurrent checks on the status and sense sequencer ports
`timescale 1ns/100ps
module tape_status_sense_assertions (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic cmd_strobe_i,
  input wire logic service_out_i,
  input wire logic command_out_i,
  input wire logic drive_counting_i,
  input wire logic [7:0] bus_in_o,
  input wire logic bus_in_par_o,
  input wire logic status_in_o,
  input wire logic service_in_o,
  input wire logic request_in_o,
  input wire logic cmd_gate_o,
  input wire logic [3:0] go_lines_o,
  input wire logic unit_check_o,
  input wire logic end_sense_o,
  input wire logic early_end_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // an answer must end the status offer quickly
  a_status_answer: assert property (
    status_in_o && (service_out_i || command_out_i) |-> ##[1:3] !status_in_o)
    else $error("status in held after answer");
  // gate never opens while the drive times its stop count
  a_gate_wait: assert property (
    $rose(cmd_gate_o) |-> !$past(drive_counting_i))
    else $error("gate set while drive counting");
  // gate follows the fall of status in
  a_gate_no_status: assert property (
    cmd_gate_o |-> !status_in_o)
    else $error("gate on while status offered");
  // go lines lag the gate by one cycle at most
  a_go_gated: assert property (
    (|go_lines_o) |-> cmd_gate_o || $past(cmd_gate_o))
    else $error("go line without gate");
  a_bus_parity: assert property (
    status_in_o || service_in_o |-> bus_in_par_o == ~^bus_in_o)
    else $error("bus in parity not odd");
  a_end_quiet: assert property (
    end_sense_o |-> !service_in_o && !status_in_o)
    else $error("end sense with service in up");
  a_early_quiet: assert property (
    early_end_o |-> !service_in_o)
    else $error("early end with service in up");
  // unit check survives status reset; only a new command clears it
  a_unit_check_hold: assert property (
    $fell(unit_check_o) |-> $past(cmd_strobe_i) || $past(cmd_strobe_i, 2))
    else $error("unit check dropped without command");
  c_end: cover property (end_sense_o);
  c_early: cover property (early_end_o);
  c_stack: cover property (request_in_o);
endmodule

// ### channel_model.sv
// host channel answering status in and service in tags
`timescale 1ns/100ps
module channel_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic status_in_i,
  input wire logic service_in_i,
  input wire logic reject_i,
  input wire logic [3:0] dly_i,
  output logic service_out_o,
  output logic command_out_o
);
  int cnt;
  // answer after a stall, hold until the tag drops; min stall lets bench pick
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      service_out_o = 1'b0;
      command_out_o = 1'b0;
      cnt = 0;
    end else begin
      #1;
      if (service_out_o || command_out_o) begin
        if (!status_in_i && !service_in_i) begin
          service_out_o = 1'b0;
          command_out_o = 1'b0;
        end
      end else if (status_in_i || service_in_i) begin
        if (cnt >= int'(dly_i)) begin
          command_out_o = reject_i;
          service_out_o = !reject_i;
          cnt = 0;
        end else begin
          cnt++;
        end
      end
    end
  end
endmodule

// ### tape_status_sense_test.sv
// self-checking bench for the status and sense sequencer
`timescale 1ns/100ps
module tape_status_sense_test;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, cmd_strobe_i = 1'b0, ce_i = 1'b1;
  logic status_pending_i = 1'b0;
  logic [7:0] bus_out_i = 8'h00;
  logic bus_out_par_i = 1'b0, select_out_i = 1'b0, drive_ready_i = 1'b1;
  logic drive_rewinding_i = 1'b0, drive_counting_i = 1'b0, drive_protect_i = 1'b0;
  logic op_end_i = 1'b0, phase_encoded_variant_i = 1'b0, reject = 1'b0;
  logic [31:0] sense_data_i = 32'h0;
  logic [3:0] dly = 4'h1, go_acc;
  logic [7:0] bus_in_o, b;
  logic bus_in_par_o, status_in_o, service_in_o, operational_in_o, burst_mode_o;
  logic request_in_o, cmd_gate_o, cmd_clear_o, unit_check_o, end_sense_o, early_end_o;
  logic service_out_i, command_out_i;
  logic [3:0] go_lines_o;
  int n_mismatch = 0, tests_run = 0, seed = 40, cyc = 0, clr_cnt, k;
  int exp_q[$];
  always #20 core_clk_i = ~core_clk_i;
  tape_status_sense uut (.core_clk_i, .reset_n_i, .ce_i, .cmd_strobe_i,
    .bus_out_i, .bus_out_par_i, .service_out_i, .command_out_i, .select_out_i,
    .disconnect_i(1'b0), .drive_ready_i, .drive_rewinding_i, .drive_counting_i,
    .drive_protect_i, .dc_feature_i(1'b0), .status_pending_i, .op_end_i,
    .phase_encoded_variant_i, .sense_data_i, .bus_in_o, .bus_in_par_o, .status_in_o,
    .service_in_o, .operational_in_o, .burst_mode_o, .request_in_o, .cmd_gate_o,
    .go_lines_o, .cmd_clear_o, .unit_check_o, .end_sense_o, .early_end_o);
  channel_model chan (.clk_i(core_clk_i), .reset_n_i, .status_in_i(status_in_o),
    .service_in_i(service_in_o), .reject_i(reject), .dly_i(dly),
    .service_out_o(service_out_i), .command_out_o(command_out_i));
  // watch clear pulses and every go line raised
  always @(posedge core_clk_i) begin
    cyc++;
    if (cmd_clear_o === 1'b1) clr_cnt++;
    go_acc = go_acc | go_lines_o;
    if (cyc > 40000) tally_and_finish(1);
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish(input int hung);
    n_mismatch += hung;
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // reset between scenarios so each starts from idle
  task automatic rst;
    reset_n_i = 1'b0;
    reject = 1'b0;
    tick(8);
    reset_n_i = 1'b1;
    clr_cnt = 0;
    go_acc = 4'h0;
  endtask
  task automatic issue(input logic [7:0] cmd, input bit good);
    bus_out_i = cmd;
    bus_out_par_i = good ? ~^cmd : ^cmd;
    select_out_i = 1'b1;
    cmd_strobe_i = 1'b1;
    tick(1);
    cmd_strobe_i = 1'b0;
  endtask
  // wait for a fresh rise of status in (si=0) or service in (si=1)
  task automatic wait_tag(input bit si, output logic [7:0] v);
    k = 0;
    while ((si ? service_in_o : status_in_o) === 1'b1 && k < 400) begin tick(1); k++; end
    while ((si ? service_in_o : status_in_o) !== 1'b1 && k < 400) begin tick(1); k++; end
    chk("tag wait", 8'(k < 400), 8'h01);
    v = bus_in_o;
  endtask
  // watch burst mode (burst=1) or request in (burst=0) for a level
  task automatic wait_for(input bit burst, input logic lvl, input int lim);
    k = 0;
    while ((burst ? burst_mode_o : request_in_o) !== lvl && k < lim) begin tick(1); k++; end
  endtask
  // sense run; stop_at below 6 answers that byte with command out
  task automatic run_sense(input int stop_at);
    rst;
    drive_ready_i = 1'b0;
    sense_data_i = $random(seed);
    phase_encoded_variant_i = sense_data_i[9];
    for (int i = 0; i < 4; i++) exp_q.push_back(int'(sense_data_i[8*i +: 8]));
    exp_q.push_back(0);
    exp_q.push_back(0);
    issue(8'h04, 1);
    wait_tag(0, b);
    chk("sense status", b, 8'h00);
    for (int i = 0; i < 6; i++) begin
      dly = 4'h1 + 4'($random(seed) & 3);
      wait_tag(1, b);
      chk("sense byte", b, 8'(exp_q.pop_front()));
      if (i == stop_at) begin
        reject = 1'b1;
        break;
      end
    end
    exp_q.delete();
    k = 0;
    while (end_sense_o !== 1'b1 && early_end_o !== 1'b1 && k < 300) begin tick(1); k++; end
    chk("sense end", {6'h00, early_end_o, end_sense_o}, stop_at < 6 ? 8'h02 : 8'h01);
    drive_ready_i = 1'b1;
  endtask
  initial begin
    run_sense(6);
    run_sense(1);
    // even command parity: unit check, no clear, kept after status reset
    rst;
    issue(tape_seq_pkg::CMD_READ, 0);
    wait_tag(0, b);
    chk("bus check unit", 8'(b[tape_seq_pkg::ST_UNIT_CHECK]), 8'h01);
    chk("bus check clear", 8'(clr_cnt), 8'h00);
    tick(70);
    chk("unit check kept", 8'(unit_check_o), 8'h01);
    chk("no read go", 8'(go_acc[tape_seq_pkg::GO_READ]), 8'h00);
    // write to protected drive: reject with clear ahead of status
    rst;
    drive_protect_i = 1'b1;
    issue(tape_seq_pkg::CMD_WRITE, 1);
    wait_tag(0, b);
    chk("reject unit", 8'(b[tape_seq_pkg::ST_UNIT_CHECK]), 8'h01);
    chk("reject clear", 8'(clr_cnt > 0), 8'h01);
    tick(70);
    chk("no write go", 8'(go_acc[tape_seq_pkg::GO_WRITE]), 8'h00);
    drive_protect_i = 1'b0;
    // status pending on the drive: busy bit and a clear block the command
    rst;
    status_pending_i = 1'b1;
    issue(tape_seq_pkg::CMD_READ, 1);
    wait_tag(0, b);
    chk("pending busy", 8'(b[tape_seq_pkg::ST_BUSY]), 8'h01);
    chk("pending clear", 8'(clr_cnt > 0), 8'h01);
    status_pending_i = 1'b0;
    // clean read held off by the stop count
    rst;
    drive_counting_i = 1'b1;
    issue(tape_seq_pkg::CMD_READ, 1);
    wait_tag(0, b);
    chk("read status", b, 8'h00);
    tick(80);
    chk("gate held", 8'(cmd_gate_o), 8'h00);
    drive_counting_i = 1'b0;
    // clock enable low freezes the armed gate
    ce_i = 1'b0;
    tick(4);
    chk("gate frozen", 8'(cmd_gate_o), 8'h00);
    ce_i = 1'b1;
    tick(4);
    chk("read go", 8'(go_acc[tape_seq_pkg::GO_READ]), 8'h01);
    chk("read op in", 8'(operational_in_o), 8'h01);
    // status rejected on a burst command: stack and re-offer
    rst;
    reject = 1'b1;
    issue(tape_seq_pkg::CMD_READ, 1);
    wait_tag(0, b);
    select_out_i = 1'b0;
    wait_for(0, 1'b1, 60);
    chk("stack request", 8'(request_in_o), 8'h01);
    chk("stack clear", 8'(clr_cnt > 0), 8'h01);
    chk("stack op in", 8'(operational_in_o), 8'h00);
    reject = 1'b0;
    select_out_i = 1'b1;
    wait_tag(0, b);
    chk("status again", b, 8'h00);
    // rewind: disconnect after delay, clear only once rewinding
    rst;
    issue(tape_seq_pkg::CMD_REWIND, 1);
    wait_tag(0, b);
    chk("rewind ce", 8'(b[tape_seq_pkg::ST_CE]), 8'h01);
    wait_for(1, 1'b0, 80);
    tick(3);
    chk("rewind disc", {6'h00, operational_in_o, burst_mode_o}, 8'h00);
    chk("rewind go", 8'(go_acc[tape_seq_pkg::GO_CTL]), 8'h01);
    chk("clear withheld", 8'(clr_cnt), 8'h00);
    drive_rewinding_i = 1'b1;
    tick(6);
    chk("rewind clear", 8'(clr_cnt > 0), 8'h01);
    tally_and_finish(0);
  end
endmodule
bind tape_status_sense tape_status_sense_assertions chk_u (.core_clk_i, .reset_n_i,
  .cmd_strobe_i, .service_out_i, .command_out_i, .drive_counting_i, .bus_in_o,
  .bus_in_par_o, .status_in_o, .service_in_o, .request_in_o, .cmd_gate_o,
  .go_lines_o, .unit_check_o, .end_sense_o, .early_end_o);
